// File: fimlb_regs.svh
// register offsets, field positions, reset values and vector layout of the fault latch bank
`ifndef FIMLB_REGS_SVH
`define FIMLB_REGS_SVH

`define FIMLB_ADDR_MASK_FIVE 8'h33
`define FIMLB_ADDR_CLOCK_EVENTS 8'h34
`define FIMLB_ADDR_CHANNEL_SUMMARY 8'h35
`define FIMLB_ADDR_IRQ_STATUS 8'h36
`define FIMLB_ADDR_IRQ_MASK 8'h37
`define FIMLB_ADDR_OUTPUT_ONE 8'h38
`define FIMLB_ADDR_OUTPUT_TWO 8'h39

`define FIMLB_MASK_FIVE_RST 8'h30
`define FIMLB_MASK_FIVE_WMASK 8'hf0
`define FIMLB_OUTPUT_ONE_RST 8'h00
`define FIMLB_OUTPUT_ONE_WMASK 8'h0c
`define FIMLB_OUTPUT_TWO_RST 8'h00
`define FIMLB_OUTPUT_TWO_WMASK 8'h02
`define FIMLB_IRQ_STATUS_RST 8'h00
`define FIMLB_IRQ_MASK_RST 8'h00

`define FIMLB_MF_MON_UP 7
`define FIMLB_MF_MON_LOW 6
`define FIMLB_MF_VOICE_UP 5
`define FIMLB_MF_VOICE_DOWN 4
`define FIMLB_O1_ADC_ONE_MASK 3
`define FIMLB_O1_ADC_TWO_MASK 2
`define FIMLB_O2_REG_MASK 1
`define FIMLB_O2_REG_FLAG 0

`define FIMLB_ST_CLOCK 7
`define FIMLB_ST_PLL 6
`define FIMLB_ST_VOICE_UP 5
`define FIMLB_ST_VOICE_DOWN 4
`define FIMLB_ST_MON_UP 3
`define FIMLB_ST_MON_LOW 2
`define FIMLB_ST_ADC 1
`define FIMLB_ST_OUTPUT 0

`define FIMLB_EV_W 19
`define FIMLB_EV_CLOCK 18
`define FIMLB_EV_PLL 17
`define FIMLB_EV_VOICE_UP 16
`define FIMLB_EV_VOICE_DOWN 15
`define FIMLB_EV_MON_UP 14
`define FIMLB_EV_MON_LOW 13
`define FIMLB_EV_ADC_ONE 12
`define FIMLB_EV_ADC_TWO 11
`define FIMLB_EV_IN_ONE 10
`define FIMLB_EV_IN_TWO 9
`define FIMLB_EV_OUT_ONE_HI 8
`define FIMLB_EV_OUT_ONE_LO 5
`define FIMLB_EV_OUT_TWO_HI 4
`define FIMLB_EV_OUT_TWO_LO 1
`define FIMLB_EV_REG 0

`define FIMLB_LT_W 15
`define FIMLB_LT_CLOCK_HI 14
`define FIMLB_LT_CLOCK_LO 13
`define FIMLB_LT_SUM_HI 12
`define FIMLB_LT_SUM_LO 9
`define FIMLB_LT_OUT_ONE_HI 8
`define FIMLB_LT_OUT_ONE_LO 5
`define FIMLB_LT_OUT_TWO_HI 4
`define FIMLB_LT_OUT_TWO_LO 1
`define FIMLB_LT_REG 0

`endif

// File: fimlb_pkg.sv
// types of the fault latch bank
package fimlb_pkg;
  `include "fimlb_regs.svh"

  typedef struct packed {
    logic [`FIMLB_EV_W-1:0] sync1;
    logic [`FIMLB_EV_W-1:0] sync2;
    logic [7:0] mask_five;
    logic [7:0] out_one_rw;
    logic [7:0] out_two_rw;
    logic [7:0] status;
    logic [7:0] irq_mask;
    logic [7:0] rdata;
    logic irq;
  } fimlb_state_type;
endpackage : fimlb_pkg

// File: fimlb_latch.sv
// bank of sticky flags that clear on request unless their event persists
module fimlb_latch #(
  parameter int WIDTH = 15
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] set_vec,
  input wire logic [WIDTH-1:0] clr_vec,
  output logic [WIDTH-1:0] flag_q
);
  import fimlb_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] flag;
  } fimlb_latch_state_type;

  fimlb_latch_state_type state_q;
  fimlb_latch_state_type state_d;

  if (WIDTH < 1) begin : g_check
    $error("fimlb_latch needs at least one flag");
  end

  always_comb begin
    // set wins over a clear in the same cycle
    state_d.flag = (state_q.flag & ~clr_vec) | set_vec;
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign flag_q = state_q.flag;

  a_set_wins_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    ##1 ((flag_q & $past(set_vec)) == $past(set_vec)))
    else $error("latched flag missed its event");

  a_hold_until_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    ##1 ((flag_q & ~$past(set_vec)) == ($past(flag_q) & ~$past(clr_vec) & ~$past(set_vec))))
    else $error("latched flag changed without clear");
endmodule : fimlb_latch

// File: fimlb_bank.sv
// interrupt mask and latched fault status bank with register port and interrupt output
`include "fimlb_regs.svh"
module fimlb_bank (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  input wire logic clock_error_evt,
  input wire logic pll_lock_evt,
  input wire logic voice_activity_detector_up_evt,
  input wire logic voice_activity_detector_down_evt,
  input wire logic general_purpose_analog_monitor_up_evt,
  input wire logic general_purpose_analog_monitor_low_evt,
  input wire logic adc_one_overload_evt,
  input wire logic adc_two_overload_evt,
  input wire logic input_one_fault,
  input wire logic input_two_fault,
  input wire logic output_one_positive_short,
  input wire logic output_one_negative_short,
  input wire logic one_driver_positive_ground,
  input wire logic one_driver_negative_ground,
  input wire logic output_two_positive_short,
  input wire logic output_two_negative_short,
  input wire logic two_driver_positive_ground,
  input wire logic two_driver_negative_ground,
  input wire logic analog_regulator_short
);
  import fimlb_pkg::*;

  fimlb_state_type state_q;
  fimlb_state_type state_d;
  logic [`FIMLB_EV_W-1:0] ev_raw;
  logic [`FIMLB_EV_W-1:0] ev;
  logic [`FIMLB_LT_W-1:0] lt_set;
  logic [`FIMLB_LT_W-1:0] lt_clr;
  logic [`FIMLB_LT_W-1:0] lt_q;
  logic [7:0] stat_set;
  logic [7:0] rd_mux;
  logic out_one_any;
  logic out_two_any;

  // fault sources come from analog circuits, outside this clock
  assign ev_raw = {clock_error_evt, pll_lock_evt,
                   voice_activity_detector_up_evt, voice_activity_detector_down_evt,
                   general_purpose_analog_monitor_up_evt, general_purpose_analog_monitor_low_evt,
                   adc_one_overload_evt, adc_two_overload_evt,
                   input_one_fault, input_two_fault,
                   output_one_positive_short, output_one_negative_short,
                   one_driver_positive_ground, one_driver_negative_ground,
                   output_two_positive_short, output_two_negative_short,
                   two_driver_positive_ground, two_driver_negative_ground,
                   analog_regulator_short};
  assign ev = state_q.sync2;
  assign out_one_any = |ev[`FIMLB_EV_OUT_ONE_HI:`FIMLB_EV_OUT_ONE_LO];
  assign out_two_any = |ev[`FIMLB_EV_OUT_TWO_HI:`FIMLB_EV_OUT_TWO_LO];

  // latched flag sources
  assign lt_set = {ev[`FIMLB_EV_CLOCK], ev[`FIMLB_EV_PLL],
                   ev[`FIMLB_EV_IN_ONE], ev[`FIMLB_EV_IN_TWO],
                   out_one_any, out_two_any,
                   ev[`FIMLB_EV_OUT_ONE_HI:`FIMLB_EV_OUT_ONE_LO],
                   ev[`FIMLB_EV_OUT_TWO_HI:`FIMLB_EV_OUT_TWO_LO],
                   ev[`FIMLB_EV_REG]};

  // a read of a latched register clears its flags at the same edge
  always_comb begin
    lt_clr = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        `FIMLB_ADDR_CLOCK_EVENTS: lt_clr[`FIMLB_LT_CLOCK_HI:`FIMLB_LT_CLOCK_LO] = '1;
        `FIMLB_ADDR_CHANNEL_SUMMARY: lt_clr[`FIMLB_LT_SUM_HI:`FIMLB_LT_SUM_LO] = '1;
        `FIMLB_ADDR_OUTPUT_ONE: lt_clr[`FIMLB_LT_OUT_ONE_HI:`FIMLB_LT_OUT_ONE_LO] = '1;
        `FIMLB_ADDR_OUTPUT_TWO: lt_clr[`FIMLB_LT_OUT_TWO_HI:`FIMLB_LT_REG] = '1;
        default: lt_clr = '0;
      endcase
    end
  end

  fimlb_latch #(
    .WIDTH(`FIMLB_LT_W)
  ) u_latch (
    .mclk(mclk),
    .arst_n(arst_n),
    .set_vec(lt_set),
    .clr_vec(lt_clr),
    .flag_q(lt_q)
  );

  // interrupt sources after the documented masks
  always_comb begin
    stat_set = 8'h00;
    stat_set[`FIMLB_ST_CLOCK] = ev[`FIMLB_EV_CLOCK];
    stat_set[`FIMLB_ST_PLL] = ev[`FIMLB_EV_PLL];
    stat_set[`FIMLB_ST_VOICE_UP] = ev[`FIMLB_EV_VOICE_UP] & ~state_q.mask_five[`FIMLB_MF_VOICE_UP];
    stat_set[`FIMLB_ST_VOICE_DOWN] = ev[`FIMLB_EV_VOICE_DOWN] & ~state_q.mask_five[`FIMLB_MF_VOICE_DOWN];
    stat_set[`FIMLB_ST_MON_UP] = ev[`FIMLB_EV_MON_UP] & ~state_q.mask_five[`FIMLB_MF_MON_UP];
    stat_set[`FIMLB_ST_MON_LOW] = ev[`FIMLB_EV_MON_LOW] & ~state_q.mask_five[`FIMLB_MF_MON_LOW];
    stat_set[`FIMLB_ST_ADC] = (ev[`FIMLB_EV_ADC_ONE] & ~state_q.out_one_rw[`FIMLB_O1_ADC_ONE_MASK])
                            | (ev[`FIMLB_EV_ADC_TWO] & ~state_q.out_one_rw[`FIMLB_O1_ADC_TWO_MASK]);
    stat_set[`FIMLB_ST_OUTPUT] = out_one_any | out_two_any
                               | (ev[`FIMLB_EV_REG] & ~state_q.out_two_rw[`FIMLB_O2_REG_MASK]);
  end

  // read mux; reserved bits read zero
  always_comb begin
    rd_mux = 8'h00;
    unique case (reg_addr)
      `FIMLB_ADDR_MASK_FIVE: rd_mux = state_q.mask_five;
      `FIMLB_ADDR_CLOCK_EVENTS: rd_mux = {lt_q[`FIMLB_LT_CLOCK_HI:`FIMLB_LT_CLOCK_LO], 6'h00};
      `FIMLB_ADDR_CHANNEL_SUMMARY: rd_mux = {lt_q[`FIMLB_LT_SUM_HI:`FIMLB_LT_SUM_LO], 4'h0};
      `FIMLB_ADDR_IRQ_STATUS: rd_mux = state_q.status;
      `FIMLB_ADDR_IRQ_MASK: rd_mux = state_q.irq_mask;
      `FIMLB_ADDR_OUTPUT_ONE: rd_mux = {lt_q[`FIMLB_LT_OUT_ONE_HI:`FIMLB_LT_OUT_ONE_LO], 4'h0}
                                     | state_q.out_one_rw;
      `FIMLB_ADDR_OUTPUT_TWO: rd_mux = {lt_q[`FIMLB_LT_OUT_TWO_HI:`FIMLB_LT_OUT_TWO_LO], 3'h0,
                                        lt_q[`FIMLB_LT_REG]} | state_q.out_two_rw;
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    state_d = state_q;
    state_d.sync1 = ev_raw;
    state_d.sync2 = state_q.sync1;
    if (reg_wr) begin
      unique case (reg_addr)
        // reserved positions are not stored, so they keep reading their reset value
        `FIMLB_ADDR_MASK_FIVE: state_d.mask_five = reg_wdata & `FIMLB_MASK_FIVE_WMASK;
        `FIMLB_ADDR_OUTPUT_ONE: state_d.out_one_rw = reg_wdata & `FIMLB_OUTPUT_ONE_WMASK;
        `FIMLB_ADDR_OUTPUT_TWO: state_d.out_two_rw = reg_wdata & `FIMLB_OUTPUT_TWO_WMASK;
        `FIMLB_ADDR_IRQ_MASK: state_d.irq_mask = reg_wdata;
        `FIMLB_ADDR_IRQ_STATUS: state_d.status = state_q.status & ~reg_wdata;
        default: state_d.status = state_q.status;
      endcase
    end
    // a new event outranks a write-one clear
    state_d.status = state_d.status | stat_set;
    state_d.rdata = reg_rd ? rd_mux : 8'h00;
    state_d.irq = |(state_d.status & ~state_d.irq_mask);
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q.sync1 <= '0;
      state_q.sync2 <= '0;
      state_q.mask_five <= `FIMLB_MASK_FIVE_RST;
      state_q.out_one_rw <= `FIMLB_OUTPUT_ONE_RST;
      state_q.out_two_rw <= `FIMLB_OUTPUT_TWO_RST;
      state_q.status <= `FIMLB_IRQ_STATUS_RST;
      state_q.irq_mask <= `FIMLB_IRQ_MASK_RST;
      state_q.rdata <= 8'h00;
      state_q.irq <= 1'b0;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata = state_q.rdata;
  assign irq = state_q.irq;

  a_mask_write_store: assert property (@(posedge mclk) disable iff (!arst_n)
    (reg_wr && reg_addr == `FIMLB_ADDR_MASK_FIVE) |=> (state_q.mask_five == ($past(reg_wdata) & 8'hf0)))
    else $error("mask register did not take the write");

  a_voice_up_gated: assert property (@(posedge mclk) disable iff (!arst_n)
    (!state_q.status[`FIMLB_ST_VOICE_UP] && state_q.mask_five[`FIMLB_MF_VOICE_UP])
    |=> !state_q.status[`FIMLB_ST_VOICE_UP])
    else $error("masked voice activity up event reached status");

  a_voice_down_set: assert property (@(posedge mclk) disable iff (!arst_n)
    (ev[`FIMLB_EV_VOICE_DOWN] && !state_q.mask_five[`FIMLB_MF_VOICE_DOWN])
    |=> state_q.status[`FIMLB_ST_VOICE_DOWN])
    else $error("unmasked voice activity down event lost");

  a_clock_read_back: assert property (@(posedge mclk) disable iff (!arst_n)
    (reg_rd && reg_addr == `FIMLB_ADDR_CLOCK_EVENTS)
    |=> (reg_rdata == {$past(lt_q[`FIMLB_LT_CLOCK_HI]), $past(lt_q[`FIMLB_LT_CLOCK_LO]), 6'h00}))
    else $error("clock event register read wrong");

  a_pll_read_clear: assert property (@(posedge mclk) disable iff (!arst_n)
    (reg_rd && reg_addr == `FIMLB_ADDR_CLOCK_EVENTS && !ev[`FIMLB_EV_PLL]) |=> !lt_q[`FIMLB_LT_CLOCK_LO])
    else $error("pll flag not cleared by read");

  a_input_summary: assert property (@(posedge mclk) disable iff (!arst_n)
    input_one_fault ##2 1'b1 |=> lt_q[`FIMLB_LT_SUM_HI])
    else $error("input one fault not latched in summary");

  a_output_summary: assert property (@(posedge mclk) disable iff (!arst_n)
    out_two_any |=> lt_q[`FIMLB_LT_SUM_LO + 0])
    else $error("output two fault not latched in summary");

  a_out_one_hold: assert property (@(posedge mclk) disable iff (!arst_n)
    (lt_q[`FIMLB_LT_OUT_ONE_HI] && !(reg_rd && reg_addr == `FIMLB_ADDR_OUTPUT_ONE))
    |=> lt_q[`FIMLB_LT_OUT_ONE_HI])
    else $error("output one short flag dropped without read");

  a_out_two_reserved: assert property (@(posedge mclk) disable iff (!arst_n)
    (reg_rd && reg_addr == `FIMLB_ADDR_OUTPUT_TWO) |=> (reg_rdata[3:2] == 2'b00))
    else $error("reserved bits of output two read nonzero");

  a_adc_masked: assert property (@(posedge mclk) disable iff (!arst_n)
    (!state_q.status[`FIMLB_ST_ADC] && (&state_q.out_one_rw[3:2])) |=> !state_q.status[`FIMLB_ST_ADC])
    else $error("masked adc overload reached status");

  a_irq_level: assert property (@(posedge mclk) disable iff (!arst_n)
    irq == (|(state_q.status & ~state_q.irq_mask)))
    else $error("interrupt level disagrees with status and mask");

  a_rdata_idle: assert property (@(posedge mclk) disable iff (!arst_n)
    !reg_rd |=> (reg_rdata == 8'h00))
    else $error("read data outside the answer cycle");
endmodule : fimlb_bank

// File: fimlb_bank_tb.sv
// self-checking testbench of the fault latch bank with a behavioural register model
module fimlb_bank_tb;
  import fimlb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, arst_n, reg_wr, reg_rd, irq;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [18:0] ev, evm;
  int n_errors, compares, cyc, r;
  int m5, o1w, o2w, st, im, lc, ls, l1, l2;

  fimlb_bank u_dut (
    .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .clock_error_evt(ev[18]), .pll_lock_evt(ev[17]),
    .voice_activity_detector_up_evt(ev[16]), .voice_activity_detector_down_evt(ev[15]),
    .general_purpose_analog_monitor_up_evt(ev[14]), .general_purpose_analog_monitor_low_evt(ev[13]),
    .adc_one_overload_evt(ev[12]), .adc_two_overload_evt(ev[11]), .input_one_fault(ev[10]),
    .input_two_fault(ev[9]), .output_one_positive_short(ev[8]), .output_one_negative_short(ev[7]),
    .one_driver_positive_ground(ev[6]), .one_driver_negative_ground(ev[5]),
    .output_two_positive_short(ev[4]), .output_two_negative_short(ev[3]),
    .two_driver_positive_ground(ev[2]), .two_driver_negative_ground(ev[1]), .analog_regulator_short(ev[0])
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // latch every held event into the model, masks as they stand now
  function automatic void upd();
    lc |= (evm[18] << 7) | (evm[17] << 6);
    ls |= (evm[10] << 7) | (evm[9] << 6) | ((|evm[8:5]) << 5) | ((|evm[4:1]) << 4);
    l1 |= evm[8:5] << 4;
    l2 |= (evm[4:1] << 4) | evm[0];
    st |= (evm[18] << 7) | (evm[17] << 6) | ((evm[16] & ~m5[5]) << 5) | ((evm[15] & ~m5[4]) << 4)
      | ((evm[14] & ~m5[7]) << 3) | ((evm[13] & ~m5[6]) << 2)
      | (((evm[12] & ~o1w[3]) | (evm[11] & ~o1w[2])) << 1) | (|evm[8:1]) | (evm[0] & ~o2w[1]);
  endfunction : upd

  function automatic int expv(input logic [7:0] a);
    case (a)
      8'h33: return m5;
      8'h34: return lc;
      8'h35: return ls;
      8'h36: return st;
      8'h37: return im;
      8'h38: return l1 | o1w;
      8'h39: return l2 | o2w;
      default: return 0;
    endcase
  endfunction : expv

  // bits that are not reserved, read-only ones included; reserved positions only ever get their reset value
  function automatic logic [7:0] wok(input logic [7:0] a);
    case (a)
      8'h33: return 8'hf0;
      8'h34: return 8'hc0;
      8'h35: return 8'hf0;
      8'h36: return 8'hff;
      8'h37: return 8'hff;
      8'h38: return 8'hfc;
      8'h39: return 8'hf3;
      default: return 8'h00;
    endcase
  endfunction : wok

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    case (a)
      8'h33: m5 = d & 8'hf0;
      8'h36: st &= ~int'(d);
      8'h37: im = d;
      8'h38: o1w = d & 8'h0c;
      8'h39: o2w = d & 8'h02;
      default: ;
    endcase
    upd();
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk("read data", 8'(expv(a)), reg_rdata);
    case (a)
      8'h34: lc = 0;
      8'h35: ls = 0;
      8'h38: l1 = 0;
      8'h39: l2 = 0;
      default: ;
    endcase
    upd();
    @(posedge mclk);
    #1 chk("idle data", 8'h00, reg_rdata);
    chk("irq", {7'h00, |(st & ~im & 32'h0000_00ff)}, {7'h00, irq});
  endtask : rd

  task automatic rdall();
    for (int a = 8'h33; a <= 8'h39; a++) begin
      rd(8'(a));
    end
  endtask : rdall

  task automatic set_ev(input logic [18:0] v);
    @(posedge mclk);
    ev <= v;
    repeat (4) @(posedge mclk);
    evm = v;
    upd();
  endtask : set_ev

  initial begin
    cyc = 0;
    forever begin
      @(posedge mclk);
      cyc++;
      if (cyc > 20000) begin
        n_errors++;
        summarize();
      end
    end
  end

  initial begin
    arst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    ev = 19'h0_0000;
    evm = 19'h0_0000;
    n_errors = 0;
    compares = 0;
    m5 = 8'h30;
    {o1w, o2w, st, im, lc, ls, l1, l2} = '0;
    r = $urandom(32'h9abc);
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    rdall();
    rd(8'h40);
    // random data, read-only places included; reserved bits keep their reset value
    for (int a = 8'h33; a <= 8'h3a; a++) begin
      wr(8'(a), 8'($urandom) & wok(8'(a)));
    end
    rdall();
    for (int mode = 0; mode < 2; mode++) begin
      wr(8'h33, mode ? 8'hf0 : 8'h00);
      wr(8'h38, mode ? 8'h0c : 8'h00);
      wr(8'h39, mode ? 8'h02 : 8'h00);
      wr(8'h37, mode ? 8'($urandom) : 8'h00);
      for (int i = 0; i < 19; i++) begin
        set_ev(19'h0_0001 << i);
        set_ev(19'h0_0000);
        rdall();
        rdall();
        wr(8'h36, 8'hff);
        rd(8'h36);
      end
    end
    // events held across reads must survive the clear
    set_ev(19'h7_ffff);
    rdall();
    rdall();
    // a write-one clear under a held event loses to the set
    wr(8'h36, 8'hff);
    rd(8'h36);
    set_ev(19'h0_0000);
    rdall();
    rdall();
    wr(8'h36, 8'hff);
    rd(8'h36);
    // random fault patterns, held across reads and then dropped
    for (int i = 0; i < 8; i++) begin
      set_ev(19'($urandom));
      rdall();
      set_ev(19'h0_0000);
      rdall();
    end
    wr(8'h36, 8'hff);
    rd(8'h36);
    summarize();
  end
endmodule : fimlb_bank_tb
